//--- inc/tmcc_pkg.sv
/*
 16-bit timer control package: register offsets, field positions, reset values,
 mode decode and the packed state and bus carrier types.
 Assumes an AXI4-Lite master with 8-bit addresses and 32-bit data.
*/
package tmcc_pkg;
   localparam logic [7:0]  TMCC_OFS_CTRL_A  = 8'h00;
   localparam logic [7:0]  TMCC_OFS_CTRL_B  = 8'h04;
   localparam logic [7:0]  TMCC_OFS_FORCE   = 8'h08;
   localparam logic [7:0]  TMCC_OFS_CNT_L   = 8'h0c;
   localparam logic [7:0]  TMCC_OFS_CNT_H   = 8'h10;
   localparam logic [7:0]  TMCC_OFS_CAP_L   = 8'h14;
   localparam logic [7:0]  TMCC_OFS_CAP_H   = 8'h18;
   localparam logic [7:0]  TMCC_OFS_CMP_L   = 8'h1c;
   localparam logic [7:0]  TMCC_OFS_CMP_H   = 8'h20;
   localparam logic [7:0]  TMCC_CMP_STRIDE  = 8'h08;
   localparam logic [7:0]  TMCC_OFS_STATUS  = 8'h34;
   localparam logic [7:0]  TMCC_OFS_MASK    = 8'h38;
   localparam logic [7:0]  TMCC_RST_BYTE    = 8'h00;
   localparam logic [15:0] TMCC_RST_WORD    = 16'h0000;
   localparam logic [7:0]  TMCC_STAT_IMPL   = 8'h2f;
   localparam logic [7:0]  TMCC_CTRL_B_WMSK = 8'hdf;
   localparam int          TMCC_ST_OVF      = 0;
   localparam int          TMCC_ST_MATCH    = 1;
   localparam int          TMCC_ST_CAP      = 5;
   localparam int          TMCC_B_FILT      = 7;
   localparam int          TMCC_B_EDGE      = 6;
   localparam int          TMCC_F_A         = 7;
   localparam int          TMCC_A_COM_A     = 6;
   localparam logic [2:0]  TMCC_CS_STOP     = 3'h0;
   localparam logic [2:0]  TMCC_CS_DIV1     = 3'h1;
   localparam logic [2:0]  TMCC_CS_DIV8     = 3'h2;
   localparam logic [2:0]  TMCC_CS_DIV64    = 3'h3;
   localparam logic [2:0]  TMCC_CS_DIV256   = 3'h4;
   localparam logic [2:0]  TMCC_CS_DIV1024  = 3'h5;
   localparam logic [2:0]  TMCC_CS_EXT_FALL = 3'h6;
   localparam logic [9:0]  TMCC_PRE_M8      = 10'h007;
   localparam logic [9:0]  TMCC_PRE_M64     = 10'h03f;
   localparam logic [9:0]  TMCC_PRE_M256    = 10'h0ff;
   localparam logic [9:0]  TMCC_PRE_M1024   = 10'h3ff;
   localparam logic [1:0]  TMCC_TOP_FIX     = 2'h0;
   localparam logic [1:0]  TMCC_TOP_CMPA    = 2'h1;
   localparam logic [1:0]  TMCC_TOP_CAP     = 2'h2;
   localparam logic [1:0]  TMCC_AT_NOW      = 2'h0;
   localparam logic [1:0]  TMCC_AT_TOP      = 2'h1;
   localparam logic [1:0]  TMCC_AT_BOT      = 2'h2;
   localparam logic [1:0]  TMCC_AT_MAX      = 2'h3;
   localparam logic [15:0] TMCC_TOP_MAX     = 16'hffff;
   localparam logic [15:0] TMCC_TOP_8BIT    = 16'h00ff;
   localparam logic [15:0] TMCC_TOP_9BIT    = 16'h01ff;
   localparam logic [15:0] TMCC_TOP_10BIT   = 16'h03ff;
   localparam logic [2:0]  TMCC_FILT_ALL1   = 3'h7;
   localparam logic [1:0]  TMCC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  TMCC_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0]  top_src;
      logic [15:0] fix_top;
      logic [1:0]  upd;
      logic [1:0]  ovf;
      logic        dual;
      logic        pwm;
      logic        tog_a;
   } tmcc_mode_t;

   typedef struct packed {
      logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
      logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
   } tmcc_axi_req_t;

   typedef struct packed {
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
   } tmcc_axi_rsp_t;

   typedef struct packed {
      tmcc_axi_rsp_t   rsp;
      logic            aw_have;
      logic [7:0]      waddr;
      logic            w_have;
      logic [7:0]      wbyte;
      logic            wen;
      logic [7:0]      ctrl_a;
      logic [7:0]      ctrl_b;
      logic [15:0]     cnt;
      logic            down;
      logic [7:0]      temp;
      logic [15:0]     cap;
      logic [2:0][15:0] cmp_buf;
      logic [2:0][15:0] cmp;
      logic [7:0]      status;
      logic [7:0]      mask;
      logic [9:0]      pre;
      logic            block;
      logic [2:0]      force_m;
      logic            irq;
   } tmcc_state_t;

   typedef struct packed {
      logic s1; logic s2; logic [2:0] hist; logic level; logic rise; logic fall;
   } tmcc_filt_t;

   function automatic tmcc_mode_t tmcc_decode(input logic [3:0] wgm);
      tmcc_mode_t m;
      m = '{TMCC_TOP_FIX, TMCC_TOP_MAX, TMCC_AT_NOW, TMCC_AT_MAX, 1'b0, 1'b0, 1'b0};
      case (wgm[1:0])
         2'h1:    m.fix_top = TMCC_TOP_8BIT;
         2'h2:    m.fix_top = TMCC_TOP_9BIT;
         2'h3:    m.fix_top = TMCC_TOP_10BIT;
         default: m.fix_top = TMCC_TOP_MAX;
      endcase
      case (wgm)
         4'h1, 4'h2, 4'h3: m = '{TMCC_TOP_FIX, m.fix_top, TMCC_AT_TOP, TMCC_AT_BOT, 1'b1, 1'b1, 1'b0};
         4'h4:             m.top_src = TMCC_TOP_CMPA;
         4'h5, 4'h6, 4'h7: m = '{TMCC_TOP_FIX, m.fix_top, TMCC_AT_TOP, TMCC_AT_TOP, 1'b0, 1'b1, 1'b0};
         4'h8: m = '{TMCC_TOP_CAP, m.fix_top, TMCC_AT_BOT, TMCC_AT_BOT, 1'b1, 1'b1, 1'b1};
         4'h9: m = '{TMCC_TOP_CMPA, m.fix_top, TMCC_AT_BOT, TMCC_AT_BOT, 1'b1, 1'b1, 1'b1};
         4'ha: m = '{TMCC_TOP_CAP, m.fix_top, TMCC_AT_TOP, TMCC_AT_BOT, 1'b1, 1'b1, 1'b1};
         4'hb: m = '{TMCC_TOP_CMPA, m.fix_top, TMCC_AT_TOP, TMCC_AT_BOT, 1'b1, 1'b1, 1'b1};
         4'hc:             m.top_src = TMCC_TOP_CAP;
         4'he: m = '{TMCC_TOP_CAP, m.fix_top, TMCC_AT_TOP, TMCC_AT_TOP, 1'b0, 1'b1, 1'b1};
         4'hf: m = '{TMCC_TOP_CMPA, m.fix_top, TMCC_AT_TOP, TMCC_AT_TOP, 1'b0, 1'b1, 1'b1};
         default: m.fix_top = TMCC_TOP_MAX;
      endcase
      return m;
   endfunction
endpackage

//--- hw/tmcc_pin_filter.sv
/*
 Pin conditioner: two-stage synchroniser, optional four-sample noise filter
 and one-cycle rise and fall pulses of the conditioned level.
 Assumes the pin is asynchronous to sys_clk.
*/
module tmcc_pin_filter
   import tmcc_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic pin,
   input  wire logic filt_en,
   output logic      rise,
   output logic      fall
);
   tmcc_filt_t f_q;
   tmcc_filt_t f_d;

   always_comb begin
      f_d      = f_q;
      f_d.s1   = pin;
      f_d.s2   = f_q.s1;
      f_d.hist = {f_q.hist[1:0], f_q.s2};
      // four equal samples: three of history plus the newest one
      if (!filt_en || ({f_q.hist, f_q.s2} == {4{f_q.s2}})) begin
         f_d.level = f_q.s2;
      end
      f_d.rise = f_d.level & ~f_q.level;
      f_d.fall = ~f_d.level & f_q.level;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end

   assign rise = f_q.rise;
   assign fall = f_q.fall;

   filter_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(filt_en) && $rose(f_q.level)) |-> ($past(f_q.hist) == TMCC_FILT_ALL1))
      else $error("filtered level rose without four high samples");
endmodule

//--- hw/tmcc_wave_unit.sv
/*
 One compare output channel: applies match, forced match and TOP events to
 the output level according to the compare-output mode and waveform class.
 Assumes event inputs are one-cycle pulses on sys_clk.
*/
module tmcc_wave_unit (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       match,
   input  wire logic       force_m,
   input  wire logic       at_top,
   input  wire logic [1:0] compare_out_mode,
   input  wire logic       down,
   input  wire logic       pwm,
   input  wire logic       dual,
   input  wire logic       tog_ok,
   output logic            pin_q
);
   logic pin_d;

   always_comb begin
      pin_d = pin_q;
      if (!pwm) begin
         // forced match behaves as a real match on the pin only
         if (match || force_m) begin
            case (compare_out_mode)
               2'h1:    pin_d = ~pin_q;
               2'h2:    pin_d = 1'b0;
               2'h3:    pin_d = 1'b1;
               default: pin_d = pin_q;
            endcase
         end
      end else if (compare_out_mode == 2'h1) begin
         if (match && tog_ok) begin
            pin_d = ~pin_q;
         end
      end else if (compare_out_mode[1]) begin
         if (match) begin
            pin_d = compare_out_mode[0] ^ (dual & down);
         end
         // top applied last: a compare value equal to TOP yields to it
         if (!dual && at_top) begin
            pin_d = ~compare_out_mode[0];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
      end
   end
endmodule

//--- hw/tmcc_timer.sv
/*
 16-bit timer/counter control: waveform mode decode, clock select and
 prescaler, input capture, forced compare strobes, counter access through
 a shared high-byte latch, status flags with masked interrupt.
 Assumes an AXI4-Lite master on sys_clk and asynchronous capture and count pins.
*/
// Functional notes
// - mode picks TOP: max, fixed, compare A, capture
// - buffer load and overflow point follow mode
// - filter needs four equal samples to change
// - edge select: zero falling, one rising
// - capture edge copies counter, sets capture flag
// - capture-as-TOP modes disconnect the capture pin
// - clock select: stop, prescaled, external edges
// - external pin counts even when driven as output
// - force bits match immediately in non-PWM modes
// - forced match sets no flag, clears nothing
// - force bits always read as zero
// - counter bytes via shared high-byte latch
// - counter write blocks next timer-clock matches
// - mode bits split over control A and B
module tmcc_timer
   import tmcc_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  tmcc_axi_req_t      axi_req,
   output tmcc_axi_rsp_t      axi_rsp,
   input  wire logic          capture_pin,
   input  wire logic          ext_count_pin,
   output logic [2:0]         compare_out_pin,
   output logic               irq
);
   tmcc_state_t s_q;
   tmcc_state_t s_d;
   tmcc_mode_t  md;
   logic [3:0]  waveform_mode_sel;
   logic [15:0] top;
   logic        tick;
   logic        cap_rise;
   logic        cap_fall;
   logic        ext_rise;
   logic        ext_fall;
   logic        cap_take;
   logic        at_top;
   logic        at_bot;
   logic        do_wr;
   logic        cnt_wr;
   logic [2:0]  match;
   logic [7:0]  st_set;
   logic [7:0]  st_clr;

   // ********************************
   // pin conditioning
   // ********************************
   tmcc_pin_filter u_cap_filt (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (capture_pin),
      .filt_en (s_q.ctrl_b[TMCC_B_FILT]),
      .rise    (cap_rise),
      .fall    (cap_fall)
   );

   // the pin is read whatever its port direction, so software can count
   tmcc_pin_filter u_ext_filt (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (ext_count_pin),
      .filt_en (1'b0),
      .rise    (ext_rise),
      .fall    (ext_fall)
   );

   // ********************************
   // next state
   // ********************************
   always_comb begin
      s_d    = s_q;
      st_set = '0;
      st_clr = '0;
      cnt_wr = 1'b0;
      match  = '0;
      waveform_mode_sel = {s_q.ctrl_b[4:3], s_q.ctrl_a[1:0]};
      md = tmcc_decode(waveform_mode_sel);
      case (md.top_src)
         TMCC_TOP_CMPA: top = s_q.cmp[0];
         TMCC_TOP_CAP:  top = s_q.cap;
         default:       top = md.fix_top;
      endcase

      // prescaler runs freely; stopping it would skew the first period
      s_d.pre = s_q.pre + 10'h001;
      case (s_q.ctrl_b[2:0])
         TMCC_CS_STOP:     tick = 1'b0;
         TMCC_CS_DIV1:     tick = 1'b1;
         TMCC_CS_DIV8:     tick = (s_q.pre & TMCC_PRE_M8) == TMCC_PRE_M8;
         TMCC_CS_DIV64:    tick = (s_q.pre & TMCC_PRE_M64) == TMCC_PRE_M64;
         TMCC_CS_DIV256:   tick = (s_q.pre & TMCC_PRE_M256) == TMCC_PRE_M256;
         TMCC_CS_DIV1024:  tick = s_q.pre == TMCC_PRE_M1024;
         TMCC_CS_EXT_FALL: tick = ext_fall;
         default:          tick = ext_rise;
      endcase

      // ********************************
      // bus slave
      // ********************************
      s_d.rsp.rvalid = s_q.rsp.rvalid & ~axi_req.rready;
      s_d.rsp.bvalid = s_q.rsp.bvalid & ~axi_req.bready;
      s_d.force_m    = '0;
      if (axi_req.awvalid && s_q.rsp.awready) begin
         s_d.aw_have = 1'b1;
         s_d.waddr   = axi_req.awaddr;
      end
      if (axi_req.wvalid && s_q.rsp.wready) begin
         s_d.w_have = 1'b1;
         s_d.wbyte  = axi_req.wdata[7:0];
         s_d.wen    = axi_req.wstrb[0];
      end
      do_wr = s_q.aw_have & s_q.w_have & ~s_q.rsp.bvalid;
      if (do_wr) begin
         s_d.aw_have    = 1'b0;
         s_d.w_have     = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp  = (s_q.waddr[1:0] == 2'h0 && s_q.waddr <= TMCC_OFS_MASK) ?
                          TMCC_RESP_OKAY : TMCC_RESP_SLVERR;
         if (s_q.wen) begin
            case (s_q.waddr)
               TMCC_OFS_CTRL_A: s_d.ctrl_a = s_q.wbyte;
               TMCC_OFS_CTRL_B: s_d.ctrl_b = s_q.wbyte & TMCC_CTRL_B_WMSK;
               // strobes only; the low five bits are ignored
               TMCC_OFS_FORCE:  s_d.force_m = {s_q.wbyte[TMCC_F_A-2], s_q.wbyte[TMCC_F_A-1],
                                               s_q.wbyte[TMCC_F_A]};
               TMCC_OFS_CNT_L: begin
                  s_d.cnt   = {s_q.temp, s_q.wbyte};
                  s_d.block = 1'b1;
                  cnt_wr    = 1'b1;
               end
               TMCC_OFS_CAP_L:  s_d.cap = {s_q.temp, s_q.wbyte};
               TMCC_OFS_CNT_H, TMCC_OFS_CAP_H: s_d.temp = s_q.wbyte;
               TMCC_OFS_STATUS: st_clr = s_q.wbyte & TMCC_STAT_IMPL;
               TMCC_OFS_MASK:   s_d.mask = s_q.wbyte & TMCC_STAT_IMPL;
               default:         s_d.temp = s_q.temp;
            endcase
            for (int i = 0; i < 3; i++) begin
               if (s_q.waddr == TMCC_OFS_CMP_L + 8'(i * 8)) begin
                  s_d.cmp_buf[i] = {s_q.temp, s_q.wbyte};
               end
               if (s_q.waddr == TMCC_OFS_CMP_H + 8'(i * 8)) begin
                  s_d.temp = s_q.wbyte;
               end
            end
         end
      end

      if (axi_req.arvalid && s_q.rsp.arready) begin
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata  = '0;
         s_d.rsp.rresp  = (axi_req.araddr[1:0] == 2'h0 && axi_req.araddr <= TMCC_OFS_MASK) ?
                          TMCC_RESP_OKAY : TMCC_RESP_SLVERR;
         case (axi_req.araddr)
            TMCC_OFS_CTRL_A: s_d.rsp.rdata[7:0] = s_q.ctrl_a;
            TMCC_OFS_CTRL_B: s_d.rsp.rdata[7:0] = s_q.ctrl_b;
            TMCC_OFS_FORCE:  s_d.rsp.rdata[7:0] = TMCC_RST_BYTE;
            TMCC_OFS_CNT_L: begin
               // low-byte read freezes the high byte for the next read
               s_d.rsp.rdata[7:0] = s_q.cnt[7:0];
               s_d.temp           = s_q.cnt[15:8];
            end
            TMCC_OFS_CAP_L: begin
               s_d.rsp.rdata[7:0] = s_q.cap[7:0];
               s_d.temp           = s_q.cap[15:8];
            end
            TMCC_OFS_CNT_H, TMCC_OFS_CAP_H: s_d.rsp.rdata[7:0] = s_q.temp;
            TMCC_OFS_STATUS: s_d.rsp.rdata[7:0] = s_q.status;
            TMCC_OFS_MASK:   s_d.rsp.rdata[7:0] = s_q.mask;
            default:         s_d.rsp.rdata[7:0] = TMCC_RST_BYTE;
         endcase
         for (int i = 0; i < 3; i++) begin
            if (axi_req.araddr == TMCC_OFS_CMP_L + 8'(i * 8)) begin
               s_d.rsp.rdata[7:0] = s_q.cmp_buf[i][7:0];
               s_d.temp           = s_q.cmp_buf[i][15:8];
            end
            if (axi_req.araddr == TMCC_OFS_CMP_H + 8'(i * 8)) begin
               s_d.rsp.rdata[7:0] = s_q.temp;
            end
         end
      end
      s_d.rsp.awready = ~s_d.aw_have & ~s_d.rsp.bvalid;
      s_d.rsp.wready  = ~s_d.w_have & ~s_d.rsp.bvalid;
      s_d.rsp.arready = ~s_d.rsp.rvalid;

      // ********************************
      // counter, compare, capture
      // ********************************
      at_top = tick & (s_q.cnt == top);
      at_bot = tick & (s_q.cnt == TMCC_RST_WORD) & s_q.down;
      for (int i = 0; i < 3; i++) begin
         match[i] = tick & (s_q.cnt == s_q.cmp[i]) & ~s_q.block;
      end
      if (tick) begin
         s_d.block = cnt_wr;
         if (!cnt_wr) begin
            if (md.dual) begin
               if (!s_q.down && s_q.cnt >= top) begin
                  s_d.down = 1'b1;
                  s_d.cnt  = (s_q.cnt == TMCC_RST_WORD) ? s_q.cnt : s_q.cnt - 16'h0001;
               end else if (s_q.down && s_q.cnt == TMCC_RST_WORD) begin
                  s_d.down = 1'b0;
                  s_d.cnt  = (top == TMCC_RST_WORD) ? s_q.cnt : 16'h0001;
               end else begin
                  s_d.cnt = s_q.down ? s_q.cnt - 16'h0001 : s_q.cnt + 16'h0001;
               end
            end else begin
               s_d.down = 1'b0;
               s_d.cnt  = (s_q.cnt >= top) ? TMCC_RST_WORD : s_q.cnt + 16'h0001;
            end
         end
      end
      case (md.ovf)
         TMCC_AT_TOP: st_set[TMCC_ST_OVF] = at_top;
         TMCC_AT_BOT: st_set[TMCC_ST_OVF] = at_bot;
         default:     st_set[TMCC_ST_OVF] = tick & (s_q.cnt == TMCC_TOP_MAX);
      endcase
      // only counter matches reach the flags, forced ones never do
      st_set[TMCC_ST_MATCH +: 3] = match;
      // pin disconnected while the capture value is TOP; flag marks TOP then
      cap_take = (s_q.ctrl_b[TMCC_B_EDGE] ? cap_rise : cap_fall)
                 & (md.top_src != TMCC_TOP_CAP);
      if (cap_take) begin
         s_d.cap = s_q.cnt;
      end
      st_set[TMCC_ST_CAP] = cap_take | (at_top & (md.top_src == TMCC_TOP_CAP));
      for (int i = 0; i < 3; i++) begin
         if ((md.upd == TMCC_AT_NOW) ||
             (md.upd == TMCC_AT_TOP && at_top && !s_q.down) ||
             (md.upd == TMCC_AT_BOT && at_bot)) begin
            s_d.cmp[i] = s_d.cmp_buf[i];
         end
      end
      // a new event wins over a clear in the same cycle
      s_d.status = (s_q.status & ~st_clr) | st_set;
      s_d.irq    = |(s_d.status & s_d.mask);
   end

   // ********************************
   // registers and outputs
   // ********************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_wave
      tmcc_wave_unit u_wave (
         .sys_clk          (sys_clk),
         .rst              (rst),
         .match            (match[g]),
         .force_m          (s_q.force_m[g] & ~md.pwm),
         .at_top           (at_top),
         .compare_out_mode (s_q.ctrl_a[TMCC_A_COM_A-2*g +: 2]),
         .down             (s_q.down),
         .pwm              (md.pwm),
         .dual             (md.dual),
         .tog_ok           (g == 0 && md.tog_a),
         .pin_q            (compare_out_pin[g])
      );
   end

   assign axi_rsp = s_q.rsp;
   assign irq     = s_q.irq;

   // ********************************
   // checks
   // ********************************
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence capture_edge_s;
      cap_take ##1 1'b1;
   endsequence

   ctc_top_a: assert property ((waveform_mode_sel == 4'h4 && at_top && !cnt_wr)
      |=> s_q.cnt == TMCC_RST_WORD)
      else $error("counter did not clear at compare A top");
   fast_ovf_a: assert property ((waveform_mode_sel == 4'h5 && tick &&
      s_q.cnt == TMCC_TOP_8BIT) |=> s_q.status[TMCC_ST_OVF])
      else $error("overflow flag missing at fast pwm top");
   capture_copy_a: assert property (capture_edge_s |->
      (s_q.cap == $past(s_q.cnt) && s_q.status[TMCC_ST_CAP]))
      else $error("capture did not copy counter and flag");
   cap_disconnect_a: assert property ((md.top_src == TMCC_TOP_CAP && !do_wr)
      |=> $stable(s_q.cap))
      else $error("capture value changed while used as top");
   stop_count_a: assert property ((s_q.ctrl_b[2:0] == TMCC_CS_STOP && !cnt_wr)
      |=> $stable(s_q.cnt))
      else $error("stopped counter moved");
   force_read_a: assert property ((axi_req.arvalid && s_q.rsp.arready &&
      axi_req.araddr == TMCC_OFS_FORCE) |=> s_q.rsp.rdata == 32'h0000_0000)
      else $error("force register read nonzero");
   force_noflag_a: assert property ((s_q.force_m != 3'h0 && !tick)
      |=> (s_q.status[3:1] & ~$past(s_q.status[3:1])) == 3'h0)
      else $error("forced match set a flag");
   write_block_a: assert property ((s_q.block && tick)
      |=> (s_q.status[3:1] & ~$past(s_q.status[3:1])) == 3'h0)
      else $error("match flagged on blocked timer clock");
   edge_sel_a: assert property ((!s_q.ctrl_b[TMCC_B_EDGE] && cap_rise && !cap_fall)
      |-> !cap_take)
      else $error("rising edge captured with falling edge selected");
endmodule

//--- tb/tmcc_pin_drv.sv
/*
 far-side model of the capture and count pins.
 assumes the bench clock; both pins are always driven, never released.
*/
module tmcc_pin_drv (
   input  wire logic sys_clk,
   output logic      capture_pin,
   output logic      ext_count_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      capture_pin = 1'b0;
      ext_count_pin = 1'b0;
   end
   // level held long enough to clear the synchroniser and the filter
   task automatic cap_set(input logic v);
      @(posedge sys_clk);
      capture_pin <= v;
      repeat (12) @(posedge sys_clk);
   endtask
   // pulse shorter than the filter window: a filtered pin must ignore it
   task automatic cap_glitch();
      @(posedge sys_clk);
      capture_pin <= ~capture_pin;
      repeat (2) @(posedge sys_clk);
      capture_pin <= ~capture_pin;
      repeat (12) @(posedge sys_clk);
   endtask
   // pin toggled by us as if software drove it as an output
   task automatic ext_pulse(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         ext_count_pin <= 1'b1;
         repeat (4) @(posedge sys_clk);
         ext_count_pin <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

//--- tb/tmcc_timer_bench.sv
/*
 self-checking bench of the timer control block over AXI4-Lite.
 assumes the pin model drives both input pins; reads are checked from a queue.
*/
module tmcc_timer_bench;
   import tmcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic cap_w, ext_w, irq;
   logic [2:0] cop;
   tmcc_axi_req_t req = '0, rq;
   tmcc_axi_rsp_t rsp, rs;
   logic [33:0] q[$], bq[$];
   int error_cnt = 0, tests_run = 0, n;
   logic [15:0] v;
   always #4 sys_clk = ~sys_clk;
   // handshake view settled half a cycle before each rising edge
   always @(negedge sys_clk) begin
      rs <= rsp;
      rq <= req;
   end
   tmcc_timer tmcc_timer_inst (.sys_clk(sys_clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
      .capture_pin(cap_w), .ext_count_pin(ext_w), .compare_out_pin(cop), .irq(irq));
   tmcc_pin_drv tmcc_pin_drv_inst (.sys_clk(sys_clk), .capture_pin(cap_w),
      .ext_count_pin(ext_w));
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic summarize();
      if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bq.push_back({TMCC_RESP_OKAY, 32'h0});
      @(posedge sys_clk);
      req.awaddr <= a;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (rq.awvalid && rs.awready) req.awvalid <= 1'b0;
         if (rq.wvalid && rs.wready) req.wvalid <= 1'b0;
      end while (!(rq.bready && rs.bvalid));
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      q.push_back(e);
      @(posedge sys_clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (rq.arvalid && rs.arready) req.arvalid <= 1'b0;
      end while (!(rq.rready && rs.rvalid));
      req.rready <= 1'b0;
   endtask
   always @(posedge sys_clk) if (rq.rready && rs.rvalid) chk({rs.rresp, rs.rdata}, q.pop_front());
   always @(posedge sys_clk) if (rq.bready && rs.bvalid) chk({rs.bresp, 32'h0}, bq.pop_front());
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      n = $urandom(72244);
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(TMCC_OFS_CTRL_B, 34'h0);
      wr(TMCC_OFS_CTRL_B, 8'hdf); // reserved bit 5 left zero
      rd(TMCC_OFS_CTRL_B, 34'hdf);
      rd(8'h3c, {TMCC_RESP_SLVERR, 32'h0});
      v = $urandom;
      wr(TMCC_OFS_CTRL_B, 8'h00); // counter stopped before any write
      wr(TMCC_OFS_CNT_H, v[15:8]);
      wr(TMCC_OFS_CNT_L, v[7:0]);
      rd(TMCC_OFS_CNT_L, {26'h0, v[7:0]});
      rd(TMCC_OFS_CNT_H, {26'h0, v[15:8]});
      wr(TMCC_OFS_CNT_H, 8'h00);
      wr(TMCC_OFS_CNT_L, 8'h00);
      v = 16'h0;
      for (int s = 7; s >= 6; s--) begin
         n = $urandom_range(5, 1);
         v = v + 16'(n);
         wr(TMCC_OFS_CTRL_B, 8'(s));
         tmcc_pin_drv_inst.ext_pulse(n);
         wr(TMCC_OFS_CTRL_B, 8'h00);
         rd(TMCC_OFS_CNT_L, {26'h0, v[7:0]});
      end
      wr(TMCC_OFS_CTRL_B, 8'hc0);
      tmcc_pin_drv_inst.cap_glitch();
      rd(TMCC_OFS_STATUS, 34'h0);
      tmcc_pin_drv_inst.cap_set(1'b1);
      rd(TMCC_OFS_STATUS, 34'h20);
      rd(TMCC_OFS_CAP_L, {26'h0, v[7:0]});
      wr(TMCC_OFS_MASK, 8'h20);
      chk({33'h0, irq}, 34'h1);
      wr(TMCC_OFS_STATUS, 8'h20);
      wr(TMCC_OFS_CTRL_B, 8'h00);
      chk({33'h0, irq}, 34'h0);
      tmcc_pin_drv_inst.cap_set(1'b0);
      rd(TMCC_OFS_STATUS, 34'h20);
      wr(TMCC_OFS_STATUS, 8'h20);
      tmcc_pin_drv_inst.cap_set(1'b1);
      rd(TMCC_OFS_STATUS, 34'h0);
      wr(TMCC_OFS_CTRL_B, 8'h18);
      tmcc_pin_drv_inst.cap_set(1'b0);
      rd(TMCC_OFS_STATUS, 34'h0);
      wr(TMCC_OFS_CTRL_B, 8'h00);
      wr(TMCC_OFS_CTRL_A, 8'h40);
      wr(TMCC_OFS_FORCE, 8'he0); // reserved low bits left zero
      repeat (2) @(posedge sys_clk);
      chk({31'h0, cop}, 34'h1);
      rd(TMCC_OFS_STATUS, 34'h0);
      rd(TMCC_OFS_FORCE, 34'h0);
      // compare A as top, rising pin edges: one wrap, the zero match blocked
      n = $urandom_range(6, 2);
      wr(TMCC_OFS_CMP_H, 8'h00);
      wr(TMCC_OFS_CMP_L, 8'(n));
      wr(TMCC_OFS_CNT_H, 8'h00);
      wr(TMCC_OFS_CNT_L, 8'h00);
      wr(TMCC_OFS_CTRL_B, 8'h0f);
      tmcc_pin_drv_inst.ext_pulse(n + 1);
      wr(TMCC_OFS_CTRL_B, 8'h00);
      rd(TMCC_OFS_CNT_L, 34'h0);
      rd(TMCC_OFS_STATUS, 34'h02);
      chk({31'h0, cop}, 34'h0);
      // fast pwm with fixed 8-bit top on the divide-by-8 clock
      wr(TMCC_OFS_STATUS, 8'h2f);
      wr(TMCC_OFS_CTRL_A, 8'h41);
      wr(TMCC_OFS_CTRL_B, 8'h0a);
      repeat (2100) @(posedge sys_clk);
      wr(TMCC_OFS_CTRL_B, 8'h00);
      rd(TMCC_OFS_STATUS, 34'h0f);
      repeat (3) @(posedge sys_clk);
      summarize();
   end
endmodule
